// ### core/sba_pkg.sv
package sba_pkg;

  // ****************************************************************
  // Address line geometry
  // ****************************************************************
  localparam int SBA_ADDR_LSB  = 3;
  localparam int SBA_AW        = 33;
  localparam int SBA_A20_IDX   = 20 - SBA_ADDR_LSB;
  localparam int SBA_UP_LO_IDX = 24 - SBA_ADDR_LSB;
  localparam int SBA_POC_ADDR_PARITY_ERROR_N  = 0;

  // ****************************************************************
  // Register map, byte addresses on the Wishbone port
  // ****************************************************************
  localparam logic [7:0] SBA_REG_CTRL    = 8'h00;
  localparam logic [7:0] SBA_REG_ADDR_LO = 8'h04;
  localparam logic [7:0] SBA_REG_ADDR_HI = 8'h08;
  localparam logic [7:0] SBA_REG_TYPE_LO = 8'h0C;
  localparam logic [7:0] SBA_REG_TYPE_HI = 8'h10;
  localparam logic [7:0] SBA_REG_STATUS  = 8'h14;
  localparam logic [7:0] SBA_REG_POC_LO  = 8'h18;
  localparam logic [7:0] SBA_REG_POC_HI  = 8'h1C;
  localparam logic [7:0] SBA_REG_SNP_LO  = 8'h20;
  localparam logic [7:0] SBA_REG_SNP_HI  = 8'h24;

  // Status and control bit positions.
  localparam int SBA_ST_BUSY   = 0;
  localparam int SBA_ST_DONE   = 1;
  localparam int SBA_ST_ABORT  = 2;
  localparam int SBA_ST_PERR   = 3;
  localparam int SBA_ST_ADDR_BIT20_MASK_N   = 4;
  localparam int SBA_ST_F100   = 5;
  localparam int SBA_ST_CFGV   = 6;
  localparam int SBA_ST_RATIO  = 8;
  localparam int SBA_CTRL_GO   = 0;

  // Cycles after the type phase during which an address parity error
  // aborts our own transaction; covers the two-flop input delay.
  localparam logic [2:0] SBA_ADDR_PARITY_ERROR_N_WIN = 3'h4;

  // Core-to-bus ratio table, indexed by the four sampled strap pins.
  localparam logic [63:0] SBA_RATIO_TABLE = 64'hFEDCBA9876543210;

  typedef enum logic [1:0] {
    SBA_IDLE  = 2'b00,
    SBA_ADDR  = 2'b01,
    SBA_TYPE  = 2'b10,
    SBA_CHECK = 2'b11
  } sba_state_e;

  typedef struct packed {
    logic              sys_rst_n;
    logic              freq_sel;
    logic              strobe_n;
    logic              par_up_n;
    logic              par_lo_n;
    logic              addr_parity_error_n_n;
    logic              addr_bit20_mask_n_n;
    logic              ignore_numeric_error_n_n;
    logic [1:0]        lint;
    logic [SBA_AW-1:0] addr_n;
  } sba_pins_s;

  typedef struct packed {
    logic [SBA_AW-1:0] addr;
    logic [SBA_AW-1:0] ttype;
  } sba_req_s;

endpackage

// ### core/sba_front.sv
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
// Overview of operation
// - Frequency select low means 66 MHz bus, high means 100 MHz bus.
// - A part limited to 66 MHz pulls the frequency select line low.
// - All agents share one bus frequency and one select line.
// - Address lines carry byte address bits 35 to 3, eight-byte aligned.
// - Strobe asserted: lines carry address; deasserted: transaction type.
// - Upper parity covers bits 35 to 24, lower covers 23 to 3.
// - Address lines are captured as power-on configuration at reset release.
// - Address mask input forces bit 20 inactive on lookups and requests; here only own requests are masked, snooped addresses keep bit 20.
// - During reset the mask, numeric and interrupt pins give clock ratio.
// - Ratio pins latch at reset release; ratio then stays frozen.
// - The initiator asserts the strobe with a valid address.
// - Strobe activation starts parity, protocol, decode and snoop checks; here only parity is checked and the snoop address captured.
// - Agents drive and observe parity error; enabled observation aborts.
// - Parity pin high when an even number of covered lines are low.
// - Outputs change and inputs latch on the rising bus clock edge.
module sba_front
  import sba_pkg::*;
#(
  parameter bit ONLY_66 = 1'b0
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              sys_reset_n_i,
  input  wire logic              freq_sel_i,
  output logic                   freq_sel_o,
  output logic                   freq_sel_oe_o,
  input  wire logic [SBA_AW-1:0] addr_n_i,
  output logic      [SBA_AW-1:0] addr_n_o,
  output logic                   addr_oe_o,
  input  wire logic              addr_strobe_n_i,
  output logic                   addr_strobe_n_o,
  output logic                   addr_strobe_oe_o,
  input  wire logic              addr_parity_upper_n_i,
  output logic                   addr_parity_upper_n_o,
  input  wire logic              addr_parity_lower_n_i,
  output logic                   addr_parity_lower_n_o,
  output logic                   addr_parity_oe_o,
  input  wire logic              addr_parity_error_n_i,
  output logic                   addr_parity_error_n_o,
  output logic                   addr_parity_error_oe_o,
  input  wire logic              addr_bit20_mask_n_i,
  input  wire logic              ignore_numeric_error_n_i,
  input  wire logic [1:0]        local_irq_pins_i
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Parity pin level for a group of logical bits; a logical one is a
  // low pin, so the pin is high when the count of ones is even.
  function automatic logic par_pin(input logic [SBA_AW-1:0] bits,
                                   input logic               upper);
    logic [SBA_AW-1:0] m;
    m = '0;
    for (int i = 0; i < SBA_AW; i++) begin
      m[i] = (i >= SBA_UP_LO_IDX) == upper;
    end
    par_pin = ~^(bits & m);
  endfunction

  function automatic logic [31:0] wmask(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    wmask = r;
  endfunction

  // Write strobe for one register address, shared by every writable register.
  function automatic logic reg_wr(input logic       wr,
                                  input logic [7:0] adr,
                                  input logic [7:0] reg_adr);
    reg_wr = wr & (adr == reg_adr);
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  sba_pins_s pin_meta;
  sba_pins_s pin;
  sba_pins_s pin_raw;

  assign pin_raw = '{sys_rst_n: sys_reset_n_i, freq_sel: freq_sel_i,
                     strobe_n: addr_strobe_n_i,
                     par_up_n: addr_parity_upper_n_i,
                     par_lo_n: addr_parity_lower_n_i,
                     addr_parity_error_n_n: addr_parity_error_n_i,
                     addr_bit20_mask_n_n: addr_bit20_mask_n_i,
                     ignore_numeric_error_n_n: ignore_numeric_error_n_i,
                     lint: local_irq_pins_i, addr_n: addr_n_i};

  // Every pin input is sampled on the rising edge only.
  always_ff @(posedge clk_i) begin
    pin_meta <= pin_raw;
    pin      <= pin_meta;
  end

  // ****************************************************************
  // Reset-time configuration capture
  // ****************************************************************
  logic              sys_rst_q;
  logic [3:0]        ratio_raw;
  logic [3:0]        ratio;
  logic [SBA_AW-1:0] poc;
  logic              cfg_valid;
  wire               rst_release = ~sys_rst_q & pin.sys_rst_n;
  wire  [3:0]        ratio_pins  = {pin.addr_bit20_mask_n_n, pin.ignore_numeric_error_n_n, pin.lint};
  wire               addr_parity_error_n_obs_en = poc[SBA_POC_ADDR_PARITY_ERROR_N];

  // The ratio comes from the last sample taken while reset was still low,
  // so a strap that moves on the release edge itself cannot slip in.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_rst_q <= 1'b0;
      ratio_raw <= 4'h0;
      ratio     <= 4'h0;
      poc       <= '0;
      cfg_valid <= 1'b0;
    end else begin
      sys_rst_q <= pin.sys_rst_n;
      if (!pin.sys_rst_n) begin
        ratio_raw <= ratio_pins;
        cfg_valid <= 1'b0;
      end
      if (rst_release) begin
        poc       <= ~pin.addr_n;
        ratio     <= SBA_RATIO_TABLE[4*ratio_raw +: 4];
        cfg_valid <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Frequency select
  // ****************************************************************
  // The pin is only ever pulled low; a part able to run at 100 MHz leaves
  // it to the board so that every agent reads the same level.
  assign freq_sel_o    = 1'b0;
  assign freq_sel_oe_o = ONLY_66;
  wire   bus_is_100    = pin.freq_sel;

  // ****************************************************************
  // Register file
  // ****************************************************************
  sba_req_s          req;
  sba_state_e        state;
  logic              done;
  logic              abort;
  logic              perr;
  logic [SBA_AW-1:0] snoop;
  logic [31:0]       rd_data;
  wire               wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire               wb_wr  = wb_hit & wb_we_i;
  wire               go     = reg_wr(wb_wr, wb_adr_i, SBA_REG_CTRL) &
                              wb_sel_i[0] & wb_dat_i[SBA_CTRL_GO];
  wire               clr_w  = reg_wr(wb_wr, wb_adr_i, SBA_REG_STATUS) &
                              wb_sel_i[0];
  wire               wr_alo = reg_wr(wb_wr, wb_adr_i, SBA_REG_ADDR_LO);
  wire               wr_ahi = reg_wr(wb_wr, wb_adr_i, SBA_REG_ADDR_HI) &
                              wb_sel_i[0];
  wire               wr_tlo = reg_wr(wb_wr, wb_adr_i, SBA_REG_TYPE_LO);
  wire               wr_thi = reg_wr(wb_wr, wb_adr_i, SBA_REG_TYPE_HI) &
                              wb_sel_i[0];
  wire  [31:0]       alo_new = wmask({req.addr[28:0], 3'h0}, wb_dat_i,
                                     wb_sel_i);
  wire  [31:0]       tlo_new = wmask(req.ttype[31:0], wb_dat_i, wb_sel_i);
  wire  [31:0]       st_word;

  assign st_word = {20'h0, ratio, 1'b0, cfg_valid, bus_is_100,
                    ~pin.addr_bit20_mask_n_n, perr, abort, done, state != SBA_IDLE};

  always_comb begin
    case (wb_adr_i)
      SBA_REG_ADDR_LO: rd_data = {req.addr[28:0], 3'h0};
      SBA_REG_ADDR_HI: rd_data = {28'h0, req.addr[32:29]};
      SBA_REG_TYPE_LO: rd_data = req.ttype[31:0];
      SBA_REG_TYPE_HI: rd_data = {31'h0, req.ttype[32]};
      SBA_REG_STATUS:  rd_data = st_word;
      SBA_REG_POC_LO:  rd_data = poc[31:0];
      SBA_REG_POC_HI:  rd_data = {31'h0, poc[32]};
      SBA_REG_SNP_LO:  rd_data = {snoop[28:0], 3'h0};
      SBA_REG_SNP_HI:  rd_data = {28'h0, snoop[32:29]};
      default:         rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      req      <= '0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit & ~wb_we_i ? rd_data : 32'h0;
      if (wr_alo) begin
        req.addr[28:0] <= alo_new[31:SBA_ADDR_LSB];
      end
      if (wr_ahi) begin
        req.addr[32:29] <= wb_dat_i[3:0];
      end
      if (wr_tlo) begin
        req.ttype[31:0] <= tlo_new;
      end
      if (wr_thi) begin
        req.ttype[32] <= wb_dat_i[0];
      end
    end
  end

  // ****************************************************************
  // Request sequencer
  // ****************************************************************
  // The mask input is asynchronous; software must not start a request
  // until the write that changed it has completed on the bus.
  logic [2:0]        win;
  sba_state_e        next_state;
  wire  [SBA_AW-1:0] out_addr = pin.addr_bit20_mask_n_n ? req.addr :
                                req.addr & ~(33'h1 << SBA_A20_IDX);
  wire               can_go   = cfg_valid & pin.sys_rst_n & go;
  wire               addr_parity_error_n_hit = ~pin.addr_parity_error_n_n & addr_parity_error_n_obs_en;

  always_comb begin
    case (state)
      SBA_IDLE:  next_state = can_go ? SBA_ADDR : SBA_IDLE;
      SBA_ADDR:  next_state = SBA_TYPE;
      SBA_TYPE:  next_state = SBA_CHECK;
      SBA_CHECK: next_state = (addr_parity_error_n_hit || win == 3'h0) ? SBA_IDLE :
                              SBA_CHECK;
      default:   next_state = SBA_IDLE;
    endcase
  end

  // A system reset drops a request at once; the pins follow one cycle
  // later, because they are driven from the next state.
  always_ff @(posedge clk_i) begin
    if (rst_i || !pin.sys_rst_n) begin
      state <= SBA_IDLE;
      win   <= 3'h0;
      done  <= 1'b0;
      abort <= 1'b0;
    end else begin
      state <= next_state;
      win   <= state == SBA_TYPE ? SBA_ADDR_PARITY_ERROR_N_WIN - 3'h1 :
               win - {2'h0, win != 3'h0};
      // A completion in the cycle of a clear still leaves its flag set.
      if (clr_w && wb_dat_i[SBA_ST_DONE]) begin
        done <= 1'b0;
      end
      if (clr_w && wb_dat_i[SBA_ST_ABORT]) begin
        abort <= 1'b0;
      end
      if (state == SBA_CHECK && addr_parity_error_n_hit) begin
        abort <= 1'b1;
      end else if (state == SBA_CHECK && win == 3'h0) begin
        done <= 1'b1;
      end
    end
  end

  // Pin drive: address phase with strobe, then type phase without it.
  // Driving from the next state puts the pins on the edge of the state
  // change, so the strobe never lags the address by a cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_n_o              <= '1;
      addr_oe_o             <= 1'b0;
      addr_strobe_n_o       <= 1'b1;
      addr_strobe_oe_o      <= 1'b0;
      addr_parity_upper_n_o <= 1'b1;
      addr_parity_lower_n_o <= 1'b1;
      addr_parity_oe_o      <= 1'b0;
    end else begin
      addr_oe_o        <= next_state == SBA_ADDR ||
                          next_state == SBA_TYPE;
      addr_strobe_oe_o <= next_state == SBA_ADDR ||
                          next_state == SBA_TYPE;
      addr_parity_oe_o <= next_state == SBA_ADDR;
      addr_strobe_n_o  <= next_state != SBA_ADDR;
      if (next_state == SBA_ADDR) begin
        addr_n_o              <= ~out_addr;
        addr_parity_upper_n_o <= par_pin(out_addr, 1'b1);
        addr_parity_lower_n_o <= par_pin(out_addr, 1'b0);
      end else if (next_state == SBA_TYPE) begin
        addr_n_o <= ~req.ttype;
      end else begin
        addr_n_o <= '1;
      end
    end
  end

  // ****************************************************************
  // Bus monitor
  // ****************************************************************
  // Our own request is not checked; the monitor is blind to it because own_q
  // is set while the sequencer is out of IDLE, as it is when the synchronised strobe lands.
  logic strobe_q;
  logic own_q;
  wire  strobe_rise = ~pin.strobe_n & strobe_q;
  wire  [SBA_AW-1:0] seen = ~pin.addr_n;
  wire  par_bad = (par_pin(seen, 1'b1) != pin.par_up_n) |
                  (par_pin(seen, 1'b0) != pin.par_lo_n);
  wire  foreign = strobe_rise & ~own_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_q               <= 1'b1;
      own_q                  <= 1'b0;
      snoop                  <= '0;
      perr                   <= 1'b0;
      addr_parity_error_n_o  <= 1'b1;
      addr_parity_error_oe_o <= 1'b0;
    end else begin
      strobe_q <= pin.strobe_n;
      own_q    <= state != SBA_IDLE;
      if (foreign) begin
        snoop <= seen;
      end
      if (foreign && par_bad) begin
        perr <= 1'b1;
      end else if (clr_w && wb_dat_i[SBA_ST_PERR]) begin
        perr <= 1'b0;
      end
      addr_parity_error_n_o  <= ~(foreign & par_bad);
      addr_parity_error_oe_o <= foreign & par_bad;
    end
  end

endmodule

// ### verif/sba_front_sva.sv
`timescale 1ns/10ps
module sba_front_sva
  import sba_pkg::*;
#(
  parameter bit ONLY_66 = 1'b0
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              freq_sel_o,
  input wire logic              freq_sel_oe_o,
  input wire logic              sys_reset_n_i,
  input wire logic              addr_bit20_mask_n_i,
  input wire logic [SBA_AW-1:0] addr_n_o,
  input wire logic              addr_oe_o,
  input wire logic              addr_strobe_n_o,
  input wire logic              addr_strobe_oe_o,
  input wire logic              addr_parity_upper_n_o,
  input wire logic              addr_parity_lower_n_o,
  input wire logic              addr_parity_oe_o,
  input wire logic              addr_parity_error_n_o,
  input wire logic              addr_parity_error_oe_o
);
  // ****************************************************************
  // Pin behaviour
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_addr;
    addr_strobe_oe_o && !addr_strobe_n_o && addr_oe_o && addr_parity_oe_o;
  endsequence
  sequence s_type;
    addr_strobe_oe_o && addr_strobe_n_o && addr_oe_o && !addr_parity_oe_o;
  endsequence
  sequence s_off;
    !addr_oe_o && !addr_strobe_oe_o;
  endsequence
  property p_phases; s_addr |=> s_type ##1 s_off; endproperty
  property p_par_up;
    addr_parity_oe_o |->
      addr_parity_upper_n_o == ~^addr_n_o[SBA_AW-1:SBA_UP_LO_IDX];
  endproperty
  property p_par_lo;
    addr_parity_oe_o |-> addr_parity_lower_n_o == ^addr_n_o[20:0];
  endproperty
  // The mask pin passes two sync flops, so it must be stable a while.
  property p_mask;
    addr_strobe_oe_o && !addr_strobe_n_o && !$past(addr_bit20_mask_n_i, 2)
      && !$past(addr_bit20_mask_n_i, 3) && !$past(addr_bit20_mask_n_i, 4)
      |-> addr_n_o[SBA_A20_IDX];
  endproperty
  property p_quiet; !sys_reset_n_i [*5] |-> !addr_strobe_oe_o; endproperty
  property p_addr_parity_error_n;
    addr_parity_error_oe_o |->
      !addr_parity_error_n_o ##1 !addr_parity_error_oe_o;
  endproperty
  property p_freq; freq_sel_oe_o == ONLY_66 && !freq_sel_o; endproperty
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  property p_ack_drop; wb_ack_o |=> !wb_ack_o; endproperty
  property p_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_phases: assert property (p_phases) else $error("bad phase order");
  a_par_up: assert property (p_par_up) else $error("bad upper parity");
  a_par_lo: assert property (p_par_lo) else $error("bad lower parity");
  a_mask: assert property (p_mask) else $error("bit 20 not masked");
  a_quiet: assert property (p_quiet) else $error("strobe in reset");
  a_addr_parity_error_n: assert property (p_addr_parity_error_n) else $error("bad error pulse");
  a_freq: assert property (p_freq) else $error("bad freq drive");
  a_ack: assert property (p_ack) else $error("late ack");
  a_ack_drop: assert property (p_ack_drop) else $error("long ack");
  a_dat: assert property (p_dat) else $error("stray read data");
endmodule

bind sba_front sba_front_sva #(.ONLY_66(ONLY_66)) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .freq_sel_o(freq_sel_o),
  .freq_sel_oe_o(freq_sel_oe_o), .sys_reset_n_i(sys_reset_n_i),
  .addr_bit20_mask_n_i(addr_bit20_mask_n_i), .addr_n_o(addr_n_o),
  .addr_oe_o(addr_oe_o), .addr_strobe_n_o(addr_strobe_n_o),
  .addr_strobe_oe_o(addr_strobe_oe_o),
  .addr_parity_upper_n_o(addr_parity_upper_n_o),
  .addr_parity_lower_n_o(addr_parity_lower_n_o),
  .addr_parity_oe_o(addr_parity_oe_o),
  .addr_parity_error_n_o(addr_parity_error_n_o),
  .addr_parity_error_oe_o(addr_parity_error_oe_o));

// ### verif/sba_agent_model.sv
`timescale 1ns/10ps
module sba_agent_model
  import sba_pkg::*;
(
  input  wire logic        clk_i,
  output logic [SBA_AW-1:0] addr_n_o,
  output logic              addr_oe_o,
  output logic              strobe_n_o,
  output logic              par_up_n_o,
  output logic              par_lo_n_o,
  output logic              par_oe_o,
  output logic              addr_parity_error_n_n_o
);
  // ****************************************************************
  // Other bus agent
  // ****************************************************************
  initial begin
    addr_n_o = '1;
    addr_oe_o = 1'b0;
    strobe_n_o = 1'b1;
    par_up_n_o = 1'b1;
    par_lo_n_o = 1'b1;
    par_oe_o = 1'b0;
    addr_parity_error_n_n_o = 1'b1;
  end
  task cfg(input logic [SBA_AW-1:0] v);
    addr_n_o <= v;
    addr_oe_o <= 1'b1;
  endtask
  task rel();
    @(posedge clk_i);
    addr_oe_o <= 1'b0;
  endtask
  // A bad request flips only the upper parity bit.
  task issue(input logic [SBA_AW-1:0] a, input logic [SBA_AW-1:0] t,
             input logic bad);
    @(posedge clk_i);
    strobe_n_o <= 1'b0;
    addr_n_o <= ~a;
    addr_oe_o <= 1'b1;
    par_oe_o <= 1'b1;
    par_up_n_o <= (~^(~a[32:21])) ^ bad;
    par_lo_n_o <= ^(~a[20:0]);
    @(posedge clk_i);
    strobe_n_o <= 1'b1;
    addr_n_o <= ~t;
    par_oe_o <= 1'b0;
    @(posedge clk_i);
    addr_oe_o <= 1'b0;
  endtask
  task addr_parity_error_n(input int n);
    @(posedge clk_i);
    addr_parity_error_n_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    addr_parity_error_n_n_o <= 1'b1;
  endtask
endmodule

// ### verif/sba_front_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module sba_front_tb;
  import sba_pkg::*;
  // ****************************************************************
  // Bench
  // ****************************************************************
  localparam logic [SBA_AW-1:0] CFG_PINS = 33'h1_2345_6778;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o, sys_rst_n, freq_pin;
  logic [7:0] wb_adr;
  logic [31:0] wb_dat, wb_dat_o;
  logic freq_sel_o, freq_sel_oe_o, addr_oe_o, str_n_o, str_oe_o;
  logic up_n_o, lo_n_o, par_oe_o, addr_parity_error_n_n_o, addr_parity_error_n_oe_o;
  logic mask_n, ignore_numeric_error_n_n, m_oe, m_str_n, m_up_n, m_lo_n, m_par_oe, m_addr_parity_error_n_n;
  logic [1:0] lint;
  logic [SBA_AW-1:0] addr_n_o, m_addr_n, addr_w, cap_addr, cap_type;
  int n_errors = 0, n_tests = 0, n_perr = 0;
  // Released address, parity and error lines float to the pull-up level, as on the real bus; the frequency line takes the board level freq_pin.
  wire str_w = str_oe_o ? str_n_o : m_str_n;
  wire up_w = par_oe_o ? up_n_o : (m_par_oe ? m_up_n : 1'b1);
  wire lo_w = par_oe_o ? lo_n_o : (m_par_oe ? m_lo_n : 1'b1);
  wire addr_parity_error_n_w = m_addr_parity_error_n_n & (addr_parity_error_n_oe_o ? addr_parity_error_n_n_o : 1'b1);
  wire freq_w = freq_sel_oe_o ? freq_sel_o : freq_pin;
  assign addr_w = addr_oe_o ? addr_n_o : (m_oe ? m_addr_n : '1);
  sba_front uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sys_reset_n_i(sys_rst_n), .freq_sel_i(freq_w), .freq_sel_o(freq_sel_o),
    .freq_sel_oe_o(freq_sel_oe_o), .addr_n_i(addr_w), .addr_n_o(addr_n_o),
    .addr_oe_o(addr_oe_o), .addr_strobe_n_i(str_w), .addr_strobe_n_o(str_n_o),
    .addr_strobe_oe_o(str_oe_o), .addr_parity_upper_n_i(up_w),
    .addr_parity_upper_n_o(up_n_o), .addr_parity_lower_n_i(lo_w),
    .addr_parity_lower_n_o(lo_n_o), .addr_parity_oe_o(par_oe_o),
    .addr_parity_error_n_i(addr_parity_error_n_w), .addr_parity_error_n_o(addr_parity_error_n_n_o),
    .addr_parity_error_oe_o(addr_parity_error_n_oe_o), .addr_bit20_mask_n_i(mask_n),
    .ignore_numeric_error_n_i(ignore_numeric_error_n_n), .local_irq_pins_i(lint));
  sba_agent_model m (.clk_i(clk_i), .addr_n_o(m_addr_n), .addr_oe_o(m_oe),
    .strobe_n_o(m_str_n), .par_up_n_o(m_up_n), .par_lo_n_o(m_lo_n),
    .par_oe_o(m_par_oe), .addr_parity_error_n_n_o(m_addr_parity_error_n_n));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (str_oe_o === 1'b1 && str_n_o === 1'b0) cap_addr <= ~addr_w;
    if (str_oe_o === 1'b1 && str_n_o === 1'b1 && addr_oe_o === 1'b1)
      cap_type <= ~addr_w;
    if (addr_parity_error_n_oe_o === 1'b1) n_perr <= n_perr + 1;
  end
  task report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
               output logic [31:0] q);
    int i;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    `CHK(wb_ack_o, 1'b1)
    if (wb_ack_o !== 1'b1) report_and_stop();
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h0, q);
    `CHK(q & m, e)
  endtask
  task wait_idle();
    logic [31:0] q;
    int i;
    for (i = 0; i < 40; i++) begin
      wb_xfer(1'b0, SBA_REG_STATUS, 32'h0, q);
      if (q[SBA_ST_BUSY] === 1'b0) break;
    end
    `CHK(q[SBA_ST_BUSY], 1'b0)
    if (i == 40) report_and_stop();
  endtask
  task fin(input string s);
    $display("test %s finished", s);
  endtask
  initial begin
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
    sys_rst_n = 1'b0;
    freq_pin = 1'b1;
    {mask_n, ignore_numeric_error_n_n, lint} = 4'hA;
    m.cfg(CFG_PINS);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    sys_rst_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    {mask_n, ignore_numeric_error_n_n, lint} <= 4'hD;
    m.rel();
    repeat (4) @(posedge clk_i);
    rd_chk(SBA_REG_STATUS, 32'h0F7F, 32'h0A60);
    rd_chk(SBA_REG_POC_LO, '1, ~CFG_PINS[31:0]);
    rd_chk(SBA_REG_POC_HI, 32'h1, {31'h0, ~CFG_PINS[32]});
    freq_pin <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd_chk(SBA_REG_STATUS, 32'h20, 32'h0);
    freq_pin <= 1'b1;
    mask_n <= 1'b0;
    fin("config");
    wr(SBA_REG_ADDR_LO, 32'h8775_4328);
    wr(SBA_REG_ADDR_HI, 32'h1);
    wr(SBA_REG_TYPE_LO, 32'hC5);
    wr(SBA_REG_TYPE_HI, 32'h0);
    wr(SBA_REG_CTRL, 32'h1);
    wait_idle();
    rd_chk(SBA_REG_STATUS, 32'h17, 32'h12);
    `CHK(cap_addr, 33'h0_30EC_A865)
    `CHK(cap_type, 33'hC5)
    wr(SBA_REG_STATUS, 32'h6);
    rd_chk(SBA_REG_STATUS, 32'h6, 32'h0);
    mask_n <= 1'b1;
    wr(SBA_REG_CTRL, 32'h1);
    for (int i = 0; i < 10 && str_n_o !== 1'b0; i++) @(posedge clk_i);
    `CHK(str_n_o, 1'b0)
    m.addr_parity_error_n(3);
    wait_idle();
    rd_chk(SBA_REG_STATUS, 32'h6, 32'h4);
    wr(SBA_REG_STATUS, 32'h6);
    fin("own request");
    m.issue(33'h0_0ABC_DEF0, 33'h3, 1'b0);
    repeat (6) @(posedge clk_i);
    rd_chk(SBA_REG_SNP_LO, '1, 32'h55E6_F780);
    rd_chk(SBA_REG_STATUS, 32'h8, 32'h0);
    m.issue(33'h1_5555_0008, 33'h3, 1'b1);
    repeat (6) @(posedge clk_i);
    `CHK(n_perr, 1)
    rd_chk(SBA_REG_STATUS, 32'h8, 32'h8);
    rd_chk(8'h40, '1, 32'h0);
    fin("snoop");
    sys_rst_n <= 1'b0;
    m.cfg(CFG_PINS | 33'h1);
    repeat (8) @(posedge clk_i);
    sys_rst_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    m.rel();
    repeat (4) @(posedge clk_i);
    rd_chk(SBA_REG_POC_LO, '1, ~CFG_PINS[31:0] & ~32'h1);
    rd_chk(SBA_REG_STATUS, 32'h0F00, 32'h0D00);
    wr(SBA_REG_CTRL, 32'h1);
    m.addr_parity_error_n(3);
    wait_idle();
    rd_chk(SBA_REG_STATUS, 32'h6, 32'h2);
    fin("observation off");
    report_and_stop();
  end
endmodule
